// *** verilog/abu_pkg.sv ***
// Purpose: Constants for the address breakpoint unit
// Assumes: AHB-Lite register access, 32-bit data, one register per aligned word
// Notes:   Register offsets are byte addresses within the unit
//
// Functional notes
// - With the enable bit set, the full 16-bit CPU address is compared with the break address and equality requests a break; with it clear no match breaks occur.
// - The enable bit is bit 7 of the control/status register, read/write, cleared by writing zero and by reset.
// - The active flag is set on every enabled address match; one means a match occurred.
// - Software writing one to the active flag requests a break regardless of any comparison.
// - The active flag clears only by a zero write or reset, and software clears it before leaving the break routine.
// - The break address is held in separate read/write high and low byte registers, both cleared by reset.
// - The wait-exit flag reads one when a break took the processor out of wait mode, zero otherwise.
// - The register holding the wait-exit flag works only in emulation mode.
// - Writing zero to the wait-exit flag clears it and the other bits of that register are reserved.
// - The flag-clear enable bit is read/write and, only while set, lets software clear module status bits in the break state.
// - While in the break state the unit asserts a halt to the timer counter.
// - In the break state the watchdog is held disabled while the high test voltage is on the reset pin.
// - In wait and stop modes the configuration is kept but no address-match break is produced.
// - A break request drives the breakpoint signal to the system integration unit, which forces the software interrupt.
// - An opcode-address match holds the instruction back until the break routine ends; an operand match lets it finish first.

package abu_pkg;
  localparam logic [11:0] ABU_OFS_CTRL_STAT  = 12'h000;
  localparam logic [11:0] ABU_OFS_ADDR_HIGH  = 12'h004;
  localparam logic [11:0] ABU_OFS_ADDR_LOW   = 12'h008;
  localparam logic [11:0] ABU_OFS_WAIT_STAT  = 12'h00C;
  localparam logic [11:0] ABU_OFS_FLAG_CTRL  = 12'h010;
  localparam logic [11:0] ABU_OFS_IRQ_STAT   = 12'h014;
  localparam logic [11:0] ABU_OFS_IRQ_MASK   = 12'h018;

  localparam int ABU_BIT_ENABLE     = 7;
  localparam int ABU_BIT_ACTIVE     = 6;
  localparam int ABU_BIT_WAIT_EXIT  = 1;
  localparam int ABU_BIT_CLR_ENABLE = 7;

  // Interrupt status layout
  localparam int ABU_IRQ_MATCH     = 0;
  localparam int ABU_IRQ_SOFT      = 1;
  localparam int ABU_IRQ_WAIT_EXIT = 2;
  localparam int ABU_IRQ_WIDTH     = 3;

  localparam logic [7:0]  ABU_RESET_BYTE = 8'h00;
  localparam logic [1:0]  ABU_HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] ABU_ZERO_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    ABU_ST_RUN,
    ABU_ST_BREAK
  } abu_state_type;
endpackage

// *** verilog/abu_ahb_slave.sv ***
// Purpose: AHB-Lite slave front end: captures the address phase, gives write strobes
// Assumes: Single word transfers, always zero wait states, OKAY response
// Notes:   Read data is produced by the parent from the captured offset

`timescale 1ns/100ps

module abu_ahb_slave
  import abu_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // AHB address phase
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  // Captured data phase
  output logic             wr_pending,
  output logic             rd_pending,
  output logic [11:0]      data_ofs
);

  logic       wr_pending_reg;
  logic       rd_pending_reg;
  logic [11:0] data_ofs_reg;
  wire        take_phase = hsel & hready & (htrans == ABU_HTRANS_NONSEQ);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pending_reg <= 1'b0;
      rd_pending_reg <= 1'b0;
      data_ofs_reg   <= 12'h000;
    end else if (hready) begin
      wr_pending_reg <= take_phase & hwrite;
      rd_pending_reg <= take_phase & ~hwrite;
      data_ofs_reg   <= haddr;
    end
  end

  assign wr_pending = wr_pending_reg;
  assign rd_pending = rd_pending_reg;
  assign data_ofs   = data_ofs_reg;

endmodule // abu_ahb_slave

// *** verilog/abu_break_unit.sv ***
// Purpose: Address breakpoint unit: match compare, break request and break-state controls
// Assumes: CPU address and cycle-valid are synchronous to sys_clk; zero-wait AHB-Lite slave
// Notes:   Break state runs from break entry until the CPU reports the ending return
//
// The AHB-Lite slave port and the register addresses were decided locally.

`timescale 1ns/100ps

module abu_break_unit
  import abu_pkg::*;
#(
  parameter int ADDR_WIDTH = 16
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  // AHB-Lite register bus
  input  wire logic                  hsel,
  input  wire logic [11:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic [31:0]                hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // CPU side
  input  wire logic [ADDR_WIDTH-1:0] cpu_addr,
  input  wire logic                  cpu_addr_valid,
  input  wire logic                  cpu_opcode_fetch,
  input  wire logic                  cpu_low_power,
  input  wire logic                  cpu_wait_mode,
  input  wire logic                  cpu_break_return,
  // System integration unit and modules
  input  wire logic                  emulation_mode,
  input  wire logic                  high_test_voltage,
  output logic                       breakpoint_request,
  output logic                       break_opcode_hold,
  output logic                       break_state,
  output logic                       timer_module_halt,
  output logic                       watchdog_unit_hold,
  output logic                       status_clear_allow,
  // Interrupt
  output logic                       break_irq
);

  logic        wr_pending;
  logic        rd_pending;
  logic [11:0] data_ofs;

  abu_ahb_slave u_slave (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .hsel       (hsel),
    .haddr      (haddr),
    .htrans     (htrans),
    .hwrite     (hwrite),
    .hready     (hready),
    .wr_pending (wr_pending),
    .rd_pending (rd_pending),
    .data_ofs   (data_ofs)
  );

  // Registers
  logic                     match_break_enable_reg;
  logic                     break_active_flag_reg;
  logic [7:0]               break_address_high_reg;
  logic [7:0]               break_address_low_reg;
  logic                     wait_exit_by_break_flag_reg;
  logic                     flag_clear_in_break_enable_reg;
  logic [ABU_IRQ_WIDTH-1:0] irq_status_reg;
  logic [ABU_IRQ_WIDTH-1:0] irq_mask_reg;
  abu_state_type            state_reg;
  logic                     breakpoint_request_reg;
  logic                     break_opcode_hold_reg;
  logic [31:0]              hrdata_reg;

  // Write decode
  wire wr_ctrl  = wr_pending & (data_ofs == ABU_OFS_CTRL_STAT);
  wire wr_high  = wr_pending & (data_ofs == ABU_OFS_ADDR_HIGH);
  wire wr_low   = wr_pending & (data_ofs == ABU_OFS_ADDR_LOW);
  wire wr_wait  = wr_pending & (data_ofs == ABU_OFS_WAIT_STAT);
  wire wr_fctl  = wr_pending & (data_ofs == ABU_OFS_FLAG_CTRL);
  wire wr_istat = wr_pending & (data_ofs == ABU_OFS_IRQ_STAT);
  wire wr_imask = wr_pending & (data_ofs == ABU_OFS_IRQ_MASK);

  wire [ADDR_WIDTH-1:0] break_address =
    ADDR_WIDTH'({break_address_high_reg, break_address_low_reg});

  // Address bus stands still in wait and stop, so no match can come from there
  wire addr_match = match_break_enable_reg & cpu_addr_valid & ~cpu_low_power
                  & (cpu_addr == break_address);
  wire soft_break = wr_ctrl & hwdata[ABU_BIT_ACTIVE];
  wire break_req  = addr_match | soft_break;
  wire in_break   = (state_reg == ABU_ST_BREAK);
  wire enter_break = break_req & ~in_break;
  wire leave_break = in_break & cpu_break_return;
  // Emulation only: outside it the wait-exit flag never sets
  wire wait_exit_event = enter_break & cpu_wait_mode & emulation_mode;

  wire [ABU_IRQ_WIDTH-1:0] irq_events;
  assign irq_events[ABU_IRQ_MATCH]     = addr_match;
  assign irq_events[ABU_IRQ_SOFT]      = soft_break;
  assign irq_events[ABU_IRQ_WAIT_EXIT] = wait_exit_event;

  wire [ABU_IRQ_WIDTH-1:0] irq_status_next =
    irq_events | (irq_status_reg & ~(wr_istat ? hwdata[ABU_IRQ_WIDTH-1:0]
                                              : {ABU_IRQ_WIDTH{1'b0}}));

  // Control/status register
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      match_break_enable_reg <= 1'b0;
      break_active_flag_reg  <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        match_break_enable_reg <= hwdata[ABU_BIT_ENABLE];
      end
      // A match in the same cycle as a zero write keeps the flag set
      if (addr_match | soft_break) begin
        break_active_flag_reg <= 1'b1;
      end else if (wr_ctrl & ~hwdata[ABU_BIT_ACTIVE]) begin
        break_active_flag_reg <= 1'b0;
      end
    end
  end

  // Break address registers
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      break_address_high_reg <= ABU_RESET_BYTE;
      break_address_low_reg  <= ABU_RESET_BYTE;
    end else begin
      if (wr_high) begin
        break_address_high_reg <= hwdata[7:0];
      end
      if (wr_low) begin
        break_address_low_reg <= hwdata[7:0];
      end
    end
  end

  // Wait status and flag control
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_exit_by_break_flag_reg    <= 1'b0;
      flag_clear_in_break_enable_reg <= 1'b0;
    end else begin
      if (wait_exit_event) begin
        wait_exit_by_break_flag_reg <= 1'b1;
      end else if (wr_wait & ~hwdata[ABU_BIT_WAIT_EXIT]) begin
        wait_exit_by_break_flag_reg <= 1'b0;
      end
      if (wr_fctl) begin
        flag_clear_in_break_enable_reg <= hwdata[ABU_BIT_CLR_ENABLE];
      end
    end
  end

  // Interrupt status and mask
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_status_reg <= {ABU_IRQ_WIDTH{1'b0}};
      irq_mask_reg   <= {ABU_IRQ_WIDTH{1'b0}};
    end else begin
      irq_status_reg <= irq_status_next;
      if (wr_imask) begin
        irq_mask_reg <= hwdata[ABU_IRQ_WIDTH-1:0];
      end
    end
  end

  // Break state sequencing
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg              <= ABU_ST_RUN;
      breakpoint_request_reg <= 1'b0;
      break_opcode_hold_reg  <= 1'b0;
    end else begin
      breakpoint_request_reg <= enter_break;
      unique case (state_reg)
        ABU_ST_RUN: begin
          if (enter_break) begin
            state_reg <= ABU_ST_BREAK;
            // Opcode match blocks that instruction; operand match lets it finish
            break_opcode_hold_reg <= addr_match & cpu_opcode_fetch;
          end
        end
        ABU_ST_BREAK: begin
          if (leave_break) begin
            state_reg             <= ABU_ST_RUN;
            break_opcode_hold_reg <= 1'b0;
          end
        end
        default: begin
          state_reg <= ABU_ST_RUN;
        end
      endcase
    end
  end

  // Read mux
  wire [31:0] rd_ctrl  = {24'h00_0000, match_break_enable_reg, break_active_flag_reg, 6'h00};
  wire [31:0] rd_high  = {24'h00_0000, break_address_high_reg};
  wire [31:0] rd_low   = {24'h00_0000, break_address_low_reg};
  wire [31:0] rd_wait  = {30'h0000_0000, wait_exit_by_break_flag_reg, 1'b0};
  wire [31:0] rd_fctl  = {24'h00_0000, flag_clear_in_break_enable_reg, 7'h00};
  wire [31:0] rd_istat = {{(32-ABU_IRQ_WIDTH){1'b0}}, irq_status_reg};
  wire [31:0] rd_imask = {{(32-ABU_IRQ_WIDTH){1'b0}}, irq_mask_reg};

  wire [31:0] rd_word =
    (data_ofs == ABU_OFS_CTRL_STAT) ? rd_ctrl  :
    (data_ofs == ABU_OFS_ADDR_HIGH) ? rd_high  :
    (data_ofs == ABU_OFS_ADDR_LOW)  ? rd_low   :
    (data_ofs == ABU_OFS_WAIT_STAT) ? rd_wait  :
    (data_ofs == ABU_OFS_FLAG_CTRL) ? rd_fctl  :
    (data_ofs == ABU_OFS_IRQ_STAT)  ? rd_istat :
    (data_ofs == ABU_OFS_IRQ_MASK)  ? rd_imask : ABU_ZERO_WORD;

  // Zero-wait reads need the word in the data phase itself, so it is decoded combinationally
  // from the offset captured by the slave; the register only holds the word after the data phase
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata_reg <= ABU_ZERO_WORD;
    end else begin
      hrdata_reg <= rd_word;
    end
  end

  assign hrdata    = rd_pending ? rd_word : hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Outputs to the rest of the chip
  assign breakpoint_request = breakpoint_request_reg;
  assign break_opcode_hold  = break_opcode_hold_reg;
  assign break_state        = in_break;
  assign timer_module_halt  = in_break;
  assign watchdog_unit_hold = in_break & high_test_voltage;
  assign status_clear_allow = ~in_break | flag_clear_in_break_enable_reg;
  assign break_irq          = |(irq_status_reg & irq_mask_reg);

endmodule // abu_break_unit

// *** testbench/abu_break_checker.sv ***
// Purpose: Concurrent checks on the break unit outputs
// Assumes: One clock domain, bound to the top module
// Notes:   Enable is internal, so match timing is left to the bench
`timescale 1ns/100ps
module abu_break_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Observed ports
  input wire logic cpu_break_return,
  input wire logic high_test_voltage,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic breakpoint_request,
  input wire logic break_opcode_hold,
  input wire logic break_state,
  input wire logic timer_module_halt,
  input wire logic watchdog_unit_hold,
  input wire logic status_clear_allow
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_pulse;
    breakpoint_request ##1 !breakpoint_request;
  endsequence
  sequence s_exit;
    break_state && cpu_break_return ##1 !break_state;
  endsequence
  chk_entry_pulse: assert property ($rose(break_state) |-> s_pulse)
    else $error("break entry without a single request pulse");
  chk_req_state: assert property (breakpoint_request |-> break_state)
    else $error("request pulse outside break state");
  chk_break_exit: assert property (break_state && cpu_break_return |-> s_exit)
    else $error("break state kept after return");
  chk_state_hold: assert property (break_state && !cpu_break_return |=> break_state)
    else $error("break state dropped without return");
  chk_timer_halt: assert property (timer_module_halt == break_state)
    else $error("timer halt differs from break state");
  chk_wdog_hold: assert property (watchdog_unit_hold == (break_state && high_test_voltage))
    else $error("watchdog hold wrong");
  chk_opcode_hold: assert property (break_opcode_hold |-> break_state)
    else $error("opcode hold outside break");
  chk_clear_gate: assert property (!break_state |-> status_clear_allow)
    else $error("status clear blocked outside break");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
endmodule // abu_break_checker

bind abu_break_unit abu_break_checker chk_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .cpu_break_return(cpu_break_return), .high_test_voltage(high_test_voltage),
  .hreadyout(hreadyout), .hresp(hresp), .breakpoint_request(breakpoint_request),
  .break_opcode_hold(break_opcode_hold), .break_state(break_state),
  .timer_module_halt(timer_module_halt), .watchdog_unit_hold(watchdog_unit_hold),
  .status_clear_allow(status_clear_allow));

// *** testbench/abu_cpu_model.sv ***
// Purpose: CPU model stepping program addresses and ending break routines
// Assumes: Runs from start_addr while run is high
// Notes:   ret_delay sets how slowly the break routine returns
`timescale 1ns/100ps
module abu_cpu_model (
  // Clock and reset
  input wire logic  sys_clk,
  input wire logic  sys_rst,
  // Bench control
  input wire logic        run,
  input wire logic [15:0] start_addr,
  input wire logic [7:0]  ret_delay,
  // Break unit side
  input wire logic        break_state,
  output logic [15:0]     cpu_addr,
  output logic            cpu_addr_valid,
  output logic            cpu_opcode_fetch,
  output logic            cpu_break_return
);
  logic [15:0] pc_reg;
  logic [7:0]  wait_reg;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {pc_reg, cpu_addr, cpu_addr_valid, cpu_opcode_fetch} <= '0;
      {cpu_break_return, wait_reg} <= '0;
    end else if (break_state) begin
      // Bus carries no program address here, so it toggles
      cpu_addr         <= ~cpu_addr;
      cpu_addr_valid   <= 1'b0;
      wait_reg         <= wait_reg + 8'h01;
      cpu_break_return <= (wait_reg == ret_delay);
    end else begin
      pc_reg           <= run ? pc_reg + 16'h0001 : start_addr;
      cpu_addr         <= run ? pc_reg + 16'h0001 : ~cpu_addr;
      cpu_addr_valid   <= run;
      cpu_opcode_fetch <= run & pc_reg[0];
      cpu_break_return <= 1'b0;
      wait_reg         <= 8'h00;
    end
  end
endmodule // abu_cpu_model

// *** testbench/test_address_breakpoint_unit.sv ***
// Purpose: Self-checking bench for the address breakpoint unit
// Assumes: Zero-wait slave, hready fed back from hreadyout
// Notes:   Reads are checked from a queue of expected words
`timescale 1ns/100ps
module test_address_breakpoint_unit;
  import abu_pkg::*;
  logic        sys_clk, sys_rst, hsel, hwrite, hreadyout, hresp, run, rd_ph;
  logic        cpu_addr_valid, cpu_opcode_fetch, cpu_low_power, cpu_wait_mode;
  logic        cpu_break_return, emulation_mode, high_test_voltage, breakpoint_request;
  logic        break_opcode_hold, break_state, timer_module_halt;
  logic        watchdog_unit_hold, status_clear_allow, break_irq;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, seed;
  logic [15:0] cpu_addr, start_addr;
  logic [7:0]  ret_delay;
  logic [31:0] exp_q[$];
  int          errors, num_checks, bp_cnt;
  wire logic   hready = hreadyout;
  logic [11:0] ofs [8] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014,
                           12'h018, 12'h01C};
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  abu_break_unit dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cpu_addr(cpu_addr),
    .cpu_addr_valid(cpu_addr_valid), .cpu_opcode_fetch(cpu_opcode_fetch),
    .cpu_low_power(cpu_low_power), .cpu_wait_mode(cpu_wait_mode),
    .cpu_break_return(cpu_break_return), .emulation_mode(emulation_mode),
    .high_test_voltage(high_test_voltage), .breakpoint_request(breakpoint_request),
    .break_opcode_hold(break_opcode_hold), .break_state(break_state),
    .timer_module_halt(timer_module_halt), .watchdog_unit_hold(watchdog_unit_hold),
    .status_clear_allow(status_clear_allow), .break_irq(break_irq));
  abu_cpu_model cpu_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .run(run),
    .start_addr(start_addr), .ret_delay(ret_delay), .break_state(break_state),
    .cpu_addr(cpu_addr), .cpu_addr_valid(cpu_addr_valid),
    .cpu_opcode_fetch(cpu_opcode_fetch), .cpu_break_return(cpu_break_return));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task fail(input string m);
    errors++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task chk_bit(input logic got, input logic exp, input string m);
    num_checks++;
    if (got !== exp) fail(m);
  endtask
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) fail("read data");
  endtask
  task stop_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Entered just after a rising edge; holds each phase until hready
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= ABU_HTRANS_NONSEQ;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= !w;
    if (!w) exp_q.push_back(e);
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    rd_ph <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0000_0000);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, e);
  endtask
  task wait_bp(input int c0);
    for (int j = 0; j < 60 && bp_cnt == c0; j++) @(posedge sys_clk);
  endtask
  task wait_idle;
    for (int j = 0; j < 200 && break_state !== 1'b0; j++) @(negedge sys_clk);
    @(posedge sys_clk);
  endtask
  // Odd break addresses land on operand cycles of the model, even ones on opcodes
  task try_match(input logic [7:0] ctl, input logic lp, input logic odd, input int n);
    int c0;
    seed = xs(seed);
    wr(ABU_OFS_ADDR_HIGH, {24'h0, seed[15:8]});
    wr(ABU_OFS_ADDR_LOW, {24'h0, seed[7:1], odd});
    wr(ABU_OFS_CTRL_STAT, {24'h0, ctl});
    c0 = bp_cnt;
    start_addr <= {seed[15:1], odd} - 16'h0006;
    cpu_low_power <= lp;
    @(posedge sys_clk);
    run <= 1'b1;
    wait_bp(c0);
    run <= 1'b0;
    chk_bit(bp_cnt - c0 == n, 1'b1, "break count");
    if (n == 1) begin
      @(negedge sys_clk);
      chk_bit(timer_module_halt, 1'b1, "timer halt");
      chk_bit(break_opcode_hold, ~odd, "opcode hold");
      chk_bit(break_irq, 1'b1, "match irq");
      @(posedge sys_clk);
      rd(ABU_OFS_CTRL_STAT, 32'h0000_00C0);
      wait_idle();
      rd(ABU_OFS_CTRL_STAT, 32'h0000_00C0);
      wr(ABU_OFS_CTRL_STAT, 32'h0000_0080);
      rd(ABU_OFS_CTRL_STAT, 32'h0000_0080);
      wr(ABU_OFS_IRQ_STAT, 32'h0000_0007);
      rd(ABU_OFS_IRQ_STAT, 32'h0000_0000);
    end
    $display("test match ctl %0h lp %0b odd %0b done", ctl, lp, odd);
  endtask
  always @(posedge sys_clk) if (rd_ph === 1'b1 && hready === 1'b1) chk_word(hrdata, exp_q.pop_front());
  always @(negedge sys_clk) if (breakpoint_request === 1'b1) bp_cnt++;
  initial begin
    #(50 * 20000);
    fail("timeout");
    stop_test();
  end
  initial begin
    {sys_rst, hsel, haddr, htrans, hwrite, hwdata, rd_ph, run, start_addr} = '0;
    {cpu_low_power, cpu_wait_mode, emulation_mode, high_test_voltage} = '0;
    {errors, num_checks, bp_cnt} = '0;
    sys_rst = 1'b1;
    ret_delay = 8'd20;
    seed = 32'h5bf7_345a;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    foreach (ofs[k]) rd(ofs[k], 32'h0000_0000);
    seed = xs(seed);
    wr(ABU_OFS_ADDR_HIGH, seed);
    rd(ABU_OFS_ADDR_HIGH, {24'h0, seed[7:0]});
    wr(ABU_OFS_FLAG_CTRL, 32'h0000_0080);
    rd(ABU_OFS_FLAG_CTRL, 32'h0000_0080);
    wr(ABU_OFS_IRQ_MASK, 32'h0000_0007);
    $display("test registers done");
    try_match(8'h80, 1'b0, 1'b0, 1);
    try_match(8'h00, 1'b0, 1'b0, 0);
    try_match(8'h80, 1'b1, 1'b0, 0);
    try_match(8'h80, 1'b0, 1'b1, 1);
    wr(ABU_OFS_IRQ_MASK, 32'h0000_0001);
    {emulation_mode, cpu_wait_mode, high_test_voltage, cpu_low_power} <= 4'b1111;
    ret_delay <= 8'd40;
    wr(ABU_OFS_CTRL_STAT, 32'h0000_0040);
    wait_bp(2);
    @(negedge sys_clk);
    chk_bit(bp_cnt == 3, 1'b1, "soft break");
    chk_bit(watchdog_unit_hold, 1'b1, "watchdog hold");
    chk_bit(break_opcode_hold, 1'b0, "no opcode hold");
    chk_bit(break_irq, 1'b0, "masked irq");
    chk_bit(status_clear_allow, 1'b1, "clear allowed");
    @(posedge sys_clk);
    wr(ABU_OFS_FLAG_CTRL, 32'h0000_0000);
    @(negedge sys_clk);
    chk_bit(status_clear_allow, 1'b0, "clear blocked");
    @(posedge sys_clk);
    rd(ABU_OFS_IRQ_STAT, 32'h0000_0006);
    rd(ABU_OFS_WAIT_STAT, 32'h0000_0002);
    wr(ABU_OFS_WAIT_STAT, 32'h0000_0000);
    rd(ABU_OFS_WAIT_STAT, 32'h0000_0000);
    wait_idle();
    {emulation_mode, ret_delay} <= {1'b0, 8'd2};
    wr(ABU_OFS_CTRL_STAT, 32'h0000_0040);
    wait_idle();
    rd(ABU_OFS_WAIT_STAT, 32'h0000_0000);
    chk_bit(bp_cnt == 4, 1'b1, "prompt soft break");
    $display("test soft break done");
    stop_test();
  end
endmodule // test_address_breakpoint_unit
